// >>> afs_pkg.sv
package afs_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_LOOP_CFG    = 8'h00;
    localparam logic [7:0] OFS_FAN_CHAR    = 8'h20;
    localparam logic [7:0] OFS_FAN_MIN     = 8'h22;
    localparam logic [7:0] OFS_FAN_FILTER  = 8'h23;
    localparam logic [7:0] OFS_LOCAL_THR   = 8'h24;
    localparam logic [7:0] OFS_REMOTE_THR  = 8'h25;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LOOP_CFG    = 8'h80;
    localparam logic [7:0] RST_FAN_CHAR    = 8'h1d;
    localparam logic [7:0] RST_FAN_MIN     = 8'h05;
    localparam logic [7:0] RST_FAN_FILTER  = 8'h10;
    localparam logic [7:0] RST_LOCAL_THR   = 8'h40;
    localparam logic [7:0] RST_REMOTE_THR  = 8'h40;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG_AUTO_BIT     = 7;
    localparam int CFG_SEL_HI       = 6;
    localparam int CFG_SEL_LO       = 5;
    localparam int CHAR_RANGE_HI    = 7;
    localparam int CHAR_RANGE_LO    = 6;
    localparam int CHAR_FREQ_HI     = 5;
    localparam int CHAR_FREQ_LO     = 3;
    localparam int CHAR_SPIN_HI     = 2;
    localparam int CHAR_SPIN_LO     = 0;
    localparam int MIN_DUTY_HI      = 3;
    localparam int MIN_DUTY_LO      = 0;
    localparam int FILT_SPIN_DIS    = 7;
    localparam int FILT_RAMP_HI     = 6;
    localparam int FILT_RAMP_LO     = 5;
    localparam int FILT_RATE_HI     = 4;
    localparam int FILT_RATE_LO     = 2;
    localparam int FILT_EN_BIT      = 0;
    localparam int THR_TMIN_HI      = 7;
    localparam int THR_TMIN_LO      = 3;
    localparam int THR_RANGE_HI     = 2;
    localparam int THR_RANGE_LO     = 0;
    localparam logic [7:0] FILT_USED_MASK = 8'hfd;

    // ------------------------------------------------------------
    // loop and timing constants
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_REMOTE      = 2'b00;
    localparam logic [1:0] SEL_FASTEST     = 2'b11;
    localparam logic [3:0] CEILING_DUTY    = 4'h0f;
    localparam logic [7:0] PWM_SLOTS       = 8'hf0;
    localparam logic [4:0] SLOTS_PER_CODE  = 5'h10;
    localparam logic [7:0] HYST_DEG        = 8'h05;
    localparam logic [2:0] RANGE_CODE_MAX  = 3'h4;
    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned SPIN_UNIT_MS   = 200;
    localparam int unsigned UPD_MAX_PER_S  = 8;
    localparam int unsigned PWM_FREQ_CHZ [8] = '{1170, 1560, 2340, 3125, 3750, 4690, 6250, 9350};
    localparam int unsigned SPIN_MULT    [8] = '{1, 2, 3, 4, 5, 10, 20, 40};

    typedef enum logic [2:0] {
        AFS_OFF  = 3'b001,
        AFS_SPIN = 3'b010,
        AFS_RUN  = 3'b100
    } afs_state_t;

endpackage

// >>> afs_channel_loop.sv
`timescale 1ns/1ps

module afs_channel_loop (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       update_en,
    input  wire logic [7:0] temp,
    input  wire logic [4:0] tmin_code,
    input  wire logic [2:0] range_code,
    input  wire logic [3:0] floor_duty_code,
    output logic      [3:0] duty_code_ff,
    output logic            running_ff
);

    logic [7:0] tmin_deg;
    logic       above;
    logic       below_hyst;
    logic [2:0] rng;
    logic [8:0] diff_half;
    logic [8:0] steps;
    logic [9:0] sum;
    logic [3:0] ramp_code;
    logic       nxt_running;

    assign tmin_deg   = {1'b0, tmin_code, 2'b00};                             // [RULE10] [RULE12]
    assign above      = temp > tmin_deg;
    assign below_hyst = ({1'b0, temp} + {1'b0, afs_pkg::HYST_DEG}) <= {1'b0, tmin_deg}; // [RULE18]
    // unused range codes act as the widest span rather than a dead loop
    assign rng        = (range_code > afs_pkg::RANGE_CODE_MAX) ? afs_pkg::RANGE_CODE_MAX : range_code; // [RULE11] [RULE13]
    // one code step per tenth of the span; the step is 2^rng half degrees
    assign diff_half  = above ? {temp - tmin_deg, 1'b0} : 9'h000;
    assign steps      = diff_half >> rng;                                     // [RULE21]
    assign sum        = {6'h00, floor_duty_code} + {1'b0, steps};             // [RULE4]
    assign ramp_code  = (sum > {6'h00, afs_pkg::CEILING_DUTY}) ? afs_pkg::CEILING_DUTY : sum[3:0]; // [RULE21]
    assign nxt_running = above ? 1'b1 : (below_hyst ? 1'b0 : running_ff);    // [RULE18]

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            running_ff   <= 1'b0;
            duty_code_ff <= 4'h0;
        end else if (update_en) begin
            running_ff   <= nxt_running;
            duty_code_ff <= nxt_running ? (above ? ramp_code : floor_duty_code) : 4'h0; // [RULE2]
        end
    end

    chk_hyst_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RULE18]
        running_ff && update_en && !below_hyst |=> running_ff)
        else $error("fan loop dropped inside hysteresis band");

    chk_code_full: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
        update_en && above && (sum >= 10'h00f) |=> duty_code_ff == afs_pkg::CEILING_DUTY)
        else $error("loop code not at ceiling past full-speed point");

endmodule // afs_channel_loop

// >>> afs_fan_loop.sv
`timescale 1ns/1ps

// How it works
// RULE1 - software programs loop before auto bit
// RULE2 - floor nibble sets duty at on-temperature
// RULE3 - duty code maps linearly, sixteen fifteenths
// RULE4 - full duty reached at floor-adjusted point
// RULE5 - bit 7 picks automatic or software duty
// RULE6 - select remote only or fastest channel
// RULE7 - spin-up time codes 200 ms to 8 s
// RULE8 - frequency code picks PWM rate
// RULE9 - speed range code picks tach divisor
// RULE10 - local on-temperature in 4 degree steps
// RULE11 - local span 5 to 80 degrees
// RULE12 - remote on-temperature in 4 degree steps
// RULE13 - remote span 5 to 80 degrees
// RULE14 - unfiltered mode applies new duty at once
// RULE15 - filter bit ramps duty toward target
// RULE16 - sample rate sets loop updates per second
// RULE17 - software writes filter before auto bit
// RULE18 - fan stays on until 5 below
// RULE19 - full drive for spin-up time first
// RULE20 - period is 240 slots, ramp 1/2/4/8
// RULE21 - one code step per tenth of span

module afs_fan_loop #(
    parameter int unsigned CLK_HZ = afs_pkg::CLK_HZ
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic [7:0] local_temp,
    input  wire logic [7:0] remote_temp,
    input  wire logic [3:0] sw_duty_code,
    output logic      [7:0] reg_rdata_ff,
    output logic            pwm_out_ff,
    output logic      [7:0] duty_slots_ff,
    output logic            fan_running_ff,
    output logic            spin_active_ff,
    output logic      [3:0] speed_range_div_ff
);

    // ------------------------------------------------------------
    // derived timing
    // ------------------------------------------------------------
    localparam int unsigned UPD_BASE  = CLK_HZ / afs_pkg::UPD_MAX_PER_S;
    localparam int unsigned SPIN_UNIT = (CLK_HZ / 1000) * afs_pkg::SPIN_UNIT_MS;

    function automatic logic [31:0] slot_cycles(input logic [2:0] code);
        logic [63:0] c;
        c = (64'(CLK_HZ) * 64'd100) / (64'(afs_pkg::PWM_FREQ_CHZ[code]) * 64'(afs_pkg::PWM_SLOTS));
        slot_cycles = (c == 64'd0) ? 32'h0000_0001 : c[31:0];
    endfunction

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] loop_cfg_ff;
    logic [7:0] fan_char_ff;
    logic [7:0] fan_min_ff;
    logic [7:0] fan_filter_ff;
    logic [7:0] local_thr_ff;
    logic [7:0] remote_thr_ff;

    // the loop follows every write at once; ordering the setup is up to software [RULE1] [RULE17]
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            loop_cfg_ff   <= afs_pkg::RST_LOOP_CFG;
            fan_char_ff   <= afs_pkg::RST_FAN_CHAR;
            fan_min_ff    <= afs_pkg::RST_FAN_MIN;
            fan_filter_ff <= afs_pkg::RST_FAN_FILTER;
            local_thr_ff  <= afs_pkg::RST_LOCAL_THR;
            remote_thr_ff <= afs_pkg::RST_REMOTE_THR;
        end else if (reg_wr_en) begin
            case (reg_addr)
                afs_pkg::OFS_LOOP_CFG:   loop_cfg_ff   <= reg_wdata;              // [RULE5] [RULE6]
                afs_pkg::OFS_FAN_CHAR:   fan_char_ff   <= reg_wdata;              // [RULE7] [RULE8] [RULE9]
                afs_pkg::OFS_FAN_MIN:    fan_min_ff    <= reg_wdata;              // [RULE2]
                afs_pkg::OFS_FAN_FILTER: fan_filter_ff <= reg_wdata & afs_pkg::FILT_USED_MASK;
                afs_pkg::OFS_LOCAL_THR:  local_thr_ff  <= reg_wdata;              // [RULE10] [RULE11]
                afs_pkg::OFS_REMOTE_THR: remote_thr_ff <= reg_wdata;              // [RULE12] [RULE13]
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                afs_pkg::OFS_LOOP_CFG:   reg_rdata_ff <= loop_cfg_ff;
                afs_pkg::OFS_FAN_CHAR:   reg_rdata_ff <= fan_char_ff;
                afs_pkg::OFS_FAN_MIN:    reg_rdata_ff <= fan_min_ff;
                afs_pkg::OFS_FAN_FILTER: reg_rdata_ff <= fan_filter_ff;
                afs_pkg::OFS_LOCAL_THR:  reg_rdata_ff <= local_thr_ff;
                afs_pkg::OFS_REMOTE_THR: reg_rdata_ff <= remote_thr_ff;
                default:                 reg_rdata_ff <= 8'h00;
            endcase
        end
    end

    logic       auto_mode;
    logic [1:0] chan_sel;
    logic [3:0] floor_duty_code;
    logic       filter_en;
    logic       spin_dis;
    logic [1:0] ramp_sel;
    logic [2:0] rate_sel;
    logic [2:0] spin_sel;
    logic [2:0] freq_sel;

    assign auto_mode       = loop_cfg_ff[afs_pkg::CFG_AUTO_BIT];                // [RULE5]
    assign chan_sel        = loop_cfg_ff[afs_pkg::CFG_SEL_HI:afs_pkg::CFG_SEL_LO];
    assign floor_duty_code = fan_min_ff[afs_pkg::MIN_DUTY_HI:afs_pkg::MIN_DUTY_LO];
    assign filter_en       = fan_filter_ff[afs_pkg::FILT_EN_BIT];               // [RULE15]
    assign spin_dis        = fan_filter_ff[afs_pkg::FILT_SPIN_DIS];
    assign ramp_sel        = fan_filter_ff[afs_pkg::FILT_RAMP_HI:afs_pkg::FILT_RAMP_LO];
    assign rate_sel        = fan_filter_ff[afs_pkg::FILT_RATE_HI:afs_pkg::FILT_RATE_LO];
    assign spin_sel        = fan_char_ff[afs_pkg::CHAR_SPIN_HI:afs_pkg::CHAR_SPIN_LO];
    assign freq_sel        = fan_char_ff[afs_pkg::CHAR_FREQ_HI:afs_pkg::CHAR_FREQ_LO];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            speed_range_div_ff <= 4'h1;
        end else begin
            speed_range_div_ff <= 4'h1 << fan_char_ff[afs_pkg::CHAR_RANGE_HI:afs_pkg::CHAR_RANGE_LO]; // [RULE9]
        end
    end

    // ------------------------------------------------------------
    // loop update rate
    // ------------------------------------------------------------
    logic [31:0] upd_cnt_ff;
    logic [31:0] upd_period;
    logic        upd_en_ff;

    // fastest rate is eight updates a second; each lower code halves it
    assign upd_period = 32'(UPD_BASE) << (3'h7 - rate_sel);                     // [RULE16]

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            upd_cnt_ff <= 32'h0000_0000;
            upd_en_ff  <= 1'b0;
        end else if (upd_cnt_ff >= upd_period - 32'h0000_0001) begin
            upd_cnt_ff <= 32'h0000_0000;
            upd_en_ff  <= 1'b1;                                                   // [RULE16]
        end else begin
            upd_cnt_ff <= upd_cnt_ff + 32'h0000_0001;
            upd_en_ff  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // channel loops
    // ------------------------------------------------------------
    logic [3:0] local_code;
    logic [3:0] remote_code;
    logic       local_run;
    logic       remote_run;

    afs_channel_loop u_local (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .update_en       (upd_en_ff),
        .temp            (local_temp),
        .tmin_code       (local_thr_ff[afs_pkg::THR_TMIN_HI:afs_pkg::THR_TMIN_LO]),
        .range_code      (local_thr_ff[afs_pkg::THR_RANGE_HI:afs_pkg::THR_RANGE_LO]),
        .floor_duty_code (floor_duty_code),
        .duty_code_ff    (local_code),
        .running_ff      (local_run)
    );

    afs_channel_loop u_remote (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .update_en       (upd_en_ff),
        .temp            (remote_temp),
        .tmin_code       (remote_thr_ff[afs_pkg::THR_TMIN_HI:afs_pkg::THR_TMIN_LO]),
        .range_code      (remote_thr_ff[afs_pkg::THR_RANGE_HI:afs_pkg::THR_RANGE_LO]),
        .floor_duty_code (floor_duty_code),
        .duty_code_ff    (remote_code),
        .running_ff      (remote_run)
    );

    logic       fastest;
    logic [3:0] target_code;
    logic       fan_on;
    logic [7:0] target_slots;

    // codes 01 and 10 behave as remote-only
    assign fastest      = (chan_sel == afs_pkg::SEL_FASTEST);                    // [RULE6]
    assign target_code  = (fastest && local_code > remote_code) ? local_code : remote_code; // [RULE6]
    assign fan_on       = fastest ? (local_run | remote_run) : remote_run;
    assign target_slots = 8'(target_code) * 8'(afs_pkg::SLOTS_PER_CODE);      // [RULE3]

    // ------------------------------------------------------------
    // spin-up sequencing
    // ------------------------------------------------------------
    afs_pkg::afs_state_t st_ff;
    logic [31:0]         spin_cnt_ff;
    logic [31:0]         spin_len;
    logic                spin_done;

    assign spin_len  = 32'(SPIN_UNIT) * 32'(afs_pkg::SPIN_MULT[spin_sel]);       // [RULE7]
    assign spin_done = spin_cnt_ff >= spin_len - 32'h0000_0001;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= afs_pkg::AFS_OFF;
        end else if (!auto_mode) begin
            st_ff <= afs_pkg::AFS_OFF;
        end else begin
            case (st_ff)
                afs_pkg::AFS_OFF:  if (fan_on) st_ff <= spin_dis ? afs_pkg::AFS_RUN : afs_pkg::AFS_SPIN; // [RULE19]
                afs_pkg::AFS_SPIN: if (!fan_on) st_ff <= afs_pkg::AFS_OFF;
                                   else if (spin_done) st_ff <= afs_pkg::AFS_RUN;  // [RULE19]
                afs_pkg::AFS_RUN:  if (!fan_on) st_ff <= afs_pkg::AFS_OFF;
                default:           st_ff <= afs_pkg::AFS_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            spin_cnt_ff <= 32'h0000_0000;
        end else if (st_ff == afs_pkg::AFS_SPIN) begin
            spin_cnt_ff <= spin_cnt_ff + 32'h0000_0001;                          // [RULE7]
        end else begin
            spin_cnt_ff <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fan_running_ff <= 1'b0;
            spin_active_ff <= 1'b0;
        end else begin
            fan_running_ff <= (st_ff != afs_pkg::AFS_OFF);
            spin_active_ff <= (st_ff == afs_pkg::AFS_SPIN);
        end
    end

    // ------------------------------------------------------------
    // applied duty
    // ------------------------------------------------------------
    logic [7:0] ramp_step;
    logic [7:0] goal_slots;
    logic [7:0] nxt_duty;

    assign ramp_step  = 8'h01 << ramp_sel;                                      // [RULE20]
    assign goal_slots = (st_ff == afs_pkg::AFS_RUN) ? target_slots : 8'h00;

    always_comb begin
        nxt_duty = duty_slots_ff;
        if (!auto_mode) begin
            nxt_duty = 8'(sw_duty_code) * 8'(afs_pkg::SLOTS_PER_CODE);         // [RULE5]
        end else if (st_ff == afs_pkg::AFS_SPIN) begin
            nxt_duty = afs_pkg::PWM_SLOTS;                                       // [RULE19]
        end else if (st_ff == afs_pkg::AFS_OFF && !filter_en) begin
            nxt_duty = 8'h00;
        end else if (upd_en_ff && !filter_en) begin
            nxt_duty = goal_slots;                                               // [RULE14]
        end else if (upd_en_ff) begin
            // step, but never overshoot the goal
            if (goal_slots > duty_slots_ff) begin
                nxt_duty = (goal_slots - duty_slots_ff > ramp_step) ? duty_slots_ff + ramp_step : goal_slots; // [RULE15]
            end else if (goal_slots < duty_slots_ff) begin
                nxt_duty = (duty_slots_ff - goal_slots > ramp_step) ? duty_slots_ff - ramp_step : goal_slots; // [RULE15]
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            duty_slots_ff <= 8'h00;
        end else begin
            duty_slots_ff <= nxt_duty;
        end
    end

    // ------------------------------------------------------------
    // pwm generator
    // ------------------------------------------------------------
    logic [31:0] slot_div_ff;
    logic        slot_en;
    logic [7:0]  slot_cnt_ff;

    assign slot_en = (slot_div_ff >= slot_cycles(freq_sel) - 32'h0000_0001);     // [RULE8]

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slot_div_ff <= 32'h0000_0000;
        end else if (slot_en) begin
            slot_div_ff <= 32'h0000_0000;
        end else begin
            slot_div_ff <= slot_div_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slot_cnt_ff <= 8'h00;
        end else if (slot_en) begin
            slot_cnt_ff <= (slot_cnt_ff == afs_pkg::PWM_SLOTS - 8'h01) ? 8'h00 : slot_cnt_ff + 8'h01; // [RULE20]
        end
    end

    // duty is compared per slot, so a change mid-period shows within that period
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwm_out_ff <= 1'b0;
        end else begin
            pwm_out_ff <= (slot_cnt_ff < duty_slots_ff);                         // [RULE3]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_reset_released;
        $past(rst) && !rst;
    endsequence

    chk_floor_reset: assert property (@(posedge clk_sys) // [RULE2]
        s_reset_released |-> floor_duty_code == 4'h5 && auto_mode && spin_sel == 3'h5)
        else $error("loop registers not at reset values");

    chk_manual_duty: assert property (@(posedge clk_sys) disable iff (rst) // [RULE5]
        !auto_mode ##1 !auto_mode |=> duty_slots_ff == 8'($past(sw_duty_code)) * 8'h10 && !fan_running_ff)
        else $error("software duty not applied");

    chk_remote_only: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
        chan_sel == 2'b00 |-> target_code == remote_code)
        else $error("local channel leaked into remote-only mode");

    chk_direct_apply: assert property (@(posedge clk_sys) disable iff (rst) // [RULE14]
        auto_mode && !filter_en && upd_en_ff && st_ff == afs_pkg::AFS_RUN
        |=> duty_slots_ff == $past(target_slots))
        else $error("unfiltered duty not applied at once");

    chk_ramp_step: assert property (@(posedge clk_sys) disable iff (rst) // [RULE15]
        auto_mode && filter_en && upd_en_ff && st_ff == afs_pkg::AFS_RUN && goal_slots > duty_slots_ff + ramp_step
        |=> duty_slots_ff == $past(duty_slots_ff) + $past(ramp_step))
        else $error("filtered ramp step wrong");

    chk_spin_full: assert property (@(posedge clk_sys) disable iff (rst) // [RULE19]
        auto_mode && st_ff == afs_pkg::AFS_SPIN ##1 auto_mode |-> duty_slots_ff == 8'hf0)
        else $error("spin-up not at full drive");

    chk_spin_end: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
        auto_mode && st_ff == afs_pkg::AFS_SPIN && spin_done |=> st_ff != afs_pkg::AFS_SPIN)
        else $error("spin-up overran its time");

    chk_slot_wrap: assert property (@(posedge clk_sys) disable iff (rst) // [RULE20]
        slot_en && slot_cnt_ff == 8'd239 |=> slot_cnt_ff == 8'h00)
        else $error("pwm period not 240 slots");

    chk_pwm_level: assert property (@(posedge clk_sys) disable iff (rst) // [RULE3]
        duty_slots_ff == 8'h00 ##1 duty_slots_ff == 8'h00 |-> !pwm_out_ff)
        else $error("pwm high at zero duty");

endmodule // afs_fan_loop

// >>> afs_fan_model.sv
`timescale 1ns/1ps

module afs_fan_model (
    input  wire logic        clk_sys,
    input  wire logic        pwm_in,
    output logic      [15:0] hi_len,
    output logic      [15:0] per_len
);
    logic [15:0] hi_ff;
    logic [15:0] per_ff;
    logic        pwm_d;
    // a fan only feels the drive level, so it measures whole periods edge to edge
    always_ff @(posedge clk_sys) begin
        pwm_d <= pwm_in;
        if (pwm_in && !pwm_d) begin
            hi_len  <= hi_ff;
            per_len <= per_ff;
            hi_ff   <= 16'h0001;
            per_ff  <= 16'h0001;
        end else begin
            hi_ff  <= hi_ff + {15'h0000, pwm_in};
            per_ff <= per_ff + 16'h0001;
        end
    end
endmodule // afs_fan_model

// >>> testbench.sv
`timescale 1ns/1ps

module testbench;
    logic        clk_sys = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, pwm, spin, run;
    logic [1:0]  sel = 2'h0;
    logic [3:0]  sw_code = 4'h0, div;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, ltemp = 8'h00, rtemp = 8'h00, rdata, duty;
    logic [15:0] hi_len, per_len;
    logic [7:0]  rd_q[$], out_q[$];
    int          n_mismatch = 0, checks_done = 0, i, j, k;
    localparam logic [7:0] OFS [7] = '{8'h00, 8'h20, 8'h22, 8'h23, 8'h24, 8'h25, 8'h21};
    localparam logic [7:0] RV [7] = '{8'h80, 8'h1d, 8'h05, 8'h10, 8'h40, 8'h40, 8'h00};
    localparam logic [7:0] AT [8][3] = '{'{8'h28, 8'h05, 8'h70}, '{8'h24, 8'h05, 8'h60}, '{8'h3c, 8'h08, 8'hf0},
        '{8'h3c, 8'h05, 8'hc0}, '{8'h4c, 8'h05, 8'hf0}, '{8'h21, 8'h05, 8'h50}, '{8'h1e, 8'h05, 8'h50},
        '{8'h1b, 8'h05, 8'h00}};

    always #2.5 clk_sys = ~clk_sys;

    // scaled clock keeps one loop update at 3000 cycles at rate code 7 (24000 at the reset rate code 4)
    afs_fan_loop #(.CLK_HZ(32'h0000_5dc0)) dut (.clk_sys(clk_sys), .rst(rst), .reg_wr_en(wr), .reg_rd_en(rd),
        .reg_addr(addr), .reg_wdata(wdata), .local_temp(ltemp), .remote_temp(rtemp), .sw_duty_code(sw_code),
        .reg_rdata_ff(rdata), .pwm_out_ff(pwm), .duty_slots_ff(duty), .fan_running_ff(run),
        .spin_active_ff(spin), .speed_range_div_ff(div));
    afs_fan_model fan (.clk_sys(clk_sys), .pwm_in(pwm), .hi_len(hi_len), .per_len(per_len));

    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge clk_sys) begin
        rd_d <= rd;
        if (rd_d) cmp("rdata", rd_q.pop_front(), rdata);
        if (sel == 2'h1) cmp("duty", out_q.pop_front(), duty);
        if (sel == 2'h2) cmp("div_run_spin", out_q.pop_front(), {div, 2'h0, run, spin});
        if (sel == 2'h3) cmp("pwm_ratio", out_q.pop_front(), 8'((32'(hi_len) * 240) / 32'(per_len)));
        // scaled clock at frequency code 3 gives three cycles a slot
        if (sel == 2'h3) cmp("pwm_period", 8'hf0, 8'(per_len / 16'h0003));
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic wreg(logic [7:0] a, logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys) wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rreg(logic [7:0] a, logic [7:0] e);
        rd_q.push_back(e);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys) rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic expect_out(logic [1:0] s, logic [7:0] e);
        out_q.push_back(e);
        sel <= s;
        @(posedge clk_sys) sel <= 2'h0;
        @(posedge clk_sys);
    endtask

    task automatic duty_is(logic [7:0] e);
        for (i = 0; i < 40000 && duty !== e; i++) @(posedge clk_sys);
        if (i == 40000) begin
            n_mismatch++;
            tally_and_finish();
        end
        expect_out(2'h1, e);
    endtask

    initial begin
        void'($urandom(32'h0000_9792));
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (k = 0; k < 7; k++) rreg(OFS[k], RV[k]);
        wreg(8'h21, 8'hff);
        wreg(8'h23, 8'hff);
        rreg(8'h21, 8'h00);
        rreg(8'h23, 8'hfd);
        j = $urandom_range(15, 0);
        wreg(8'h22, 8'(j));
        rreg(8'h22, 8'(j));
        for (k = 0; k < 4; k++) begin
            wreg(8'h20, {2'(k), 6'h18});
            expect_out(2'h2, {4'(1 << k), 4'h0});
        end
        $display("test registers done");
        wreg(8'h00, 8'h00);
        for (k = 0; k < 3; k++) begin
            j = (k == 0) ? 15 : (k == 1) ? 0 : $urandom_range(14, 1);
            sw_code <= 4'(j);
            duty_is(8'(j * 16));
        end
        wreg(8'h23, 8'h9c);
        wreg(8'h25, 8'h43);
        wreg(8'h24, 8'h04);
        wreg(8'h00, 8'h80);
        for (k = 0; k < 8; k++) begin
            wreg(8'h22, AT[k][1]);
            rtemp <= AT[k][0];
            // an unchanged duty needs two updates to pass before it means anything
            if (k > 0 && AT[k][2] == AT[k-1][2]) repeat (9100) @(posedge clk_sys);
            duty_is(AT[k][2]);
        end
        rtemp <= 8'h28;
        duty_is(8'h70);
        repeat (1500) @(posedge clk_sys);
        expect_out(2'h3, 8'h70);
        ltemp <= 8'h50;
        wreg(8'h00, 8'he0);
        duty_is(8'hf0);
        ltemp <= 8'h00;
        duty_is(8'h70);
        wreg(8'h23, 8'hfd);
        rtemp <= 8'h2c;
        for (i = 0; i < 20000 && duty === 8'h70; i++) @(posedge clk_sys);
        if (i == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
        expect_out(2'h1, 8'h78);
        duty_is(8'h80);
        wreg(8'h23, 8'h1c);
        // local loop at on-temperature 0 can never fall 5 below, so it would keep the fan on
        wreg(8'h00, 8'h80);
        rtemp <= 8'h14;
        duty_is(8'h00);
        rtemp <= 8'h28;
        for (i = 0; i < 20000 && spin !== 1'b1; i++) @(posedge clk_sys);
        if (i == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
        expect_out(2'h2, 8'h83);
        duty_is(8'hf0);
        duty_is(8'h70);
        $display("test loop done");
        tally_and_finish();
    end
endmodule // testbench
